// ### logic/dsf_status_flags.sv
// Purpose: Speed-loop status flags, reference select and option bits
// Assumes: tick_i is the control-loop tick, one cycle wide
// Notes:   Three 16-bit bit words behind a simple parameter port
//
// What this block does
// - Digital mode: internal or frequency reference
// - Frequency input as freq/dir or quadrature
// - Overspeed flag when speed magnitude exceeds threshold
// - Relative window: error between limits sets in-speed
// - Absolute window: speed between limits sets in-speed
// - Zero-speed flag is 0 at zero speed
// - Forward flag is 0 at positive speed
// - Drive-ok is 1 without alarms
// - Hardware-enable bit follows enable, readable everywhere
// - Phasing bit set after successful phasing
// - Two user-writable alarm bits, external and auxiliary
// - Sync message sets both watchdog bits
// - Thermal full scale sets flag, limits current
// - Transient bus error sets bus-warning flag
// - Permanent bus error sets bus-off flag
// - Read-only converter-enabled status bit
// - Virtual encoder follows its enable bit, default 0
// - Supply selection sampled only at start-up
// - Torque-mode bit turns analogue into torque command
// - Digital-select bit picks analogue or digital reference
// - Frequency format defaults to quadrature
`timescale 1ns/1ns
`default_nettype none

module dsf_status_flags (
	// Clock and reset
	input  wire logic                 clk_sys_i,
	input  wire logic                 rstn_i,
	input  wire logic                 tick_i,
	// Parameter port
	input  wire dsf_pkg::dsf_wr_t     wr_i,
	input  wire logic [1:0]           rd_sel_i,
	output logic [15:0]               rd_data_o,
	// Speed values and references
	input  wire logic signed [15:0]   measured_speed_i,
	input  wire dsf_pkg::dsf_limits_t limits_i,
	input  wire logic signed [15:0]   analog_ref_i,
	input  wire logic signed [15:0]   internal_reference_i,
	input  wire logic [15:0]          thermal_load_level_i,
	input  wire logic                 supply_saved_i,
	// Frequency input
	input  wire logic                 freq_a_i,
	input  wire logic                 freq_b_i,
	// Drive events and levels
	input  wire dsf_pkg::dsf_stat_in_t stat_i,
	// Outputs to the drive
	output logic signed [15:0]        speed_ref_o,
	output logic signed [15:0]        torque_cmd_o,
	output logic signed [15:0]        frequency_reference_o,
	output logic                      torque_mode_o,
	output logic                      current_limit_nominal_o,
	output logic                      virtual_encoder_en_o,
	output logic                      supply_low_o
);
	import dsf_pkg::*;

	// Quadrature step: +1, -1 or 0 from old and new phase pairs
	function automatic logic signed [1:0] quad_step(input logic [1:0] o, input logic [1:0] n);
		logic signed [1:0] s;
		s = 2'sh0;
		unique case ({o, n})
			4'h1, 4'h7, 4'hE, 4'h8: s = 2'sh1;
			4'h2, 4'hB, 4'hD, 4'h4: s = -2'sh1;
			default: s = 2'sh0;
		endcase
		return s;
	endfunction

	// ----------------------------------------
	// Configuration words
	// ----------------------------------------
	logic [15:0] spd_cfg_q, spd_cfg_d;
	logic [15:0] opt_cfg_q, opt_cfg_d;
	logic        started_q, started_d;
	logic        supply_q,  supply_d;

	always_comb begin
		spd_cfg_d = spd_cfg_q;
		opt_cfg_d = opt_cfg_q;
		started_d = 1'b1;
		supply_d  = supply_q;
		// Stored as written; software keeps the reserved bit at zero
		if (wr_i.en && wr_i.sel == DSF_SEL_SPEED_CFG) begin
			spd_cfg_d = wr_i.data;
		end
		if (wr_i.en && wr_i.sel == DSF_SEL_OPTION_CFG) begin
			opt_cfg_d = wr_i.data;
		end
		// Saved value caught once; later writes wait for a restart
		if (!started_q) begin
			supply_d = supply_saved_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			spd_cfg_q <= DSF_SPEED_CFG_RST;
			opt_cfg_q <= DSF_OPTION_CFG_RST;
			started_q <= 1'b0;
			supply_q  <= 1'b0;
		end else begin
			spd_cfg_q <= spd_cfg_d;
			opt_cfg_q <= opt_cfg_d;
			started_q <= started_d;
			supply_q  <= supply_d;
		end
	end

	// ----------------------------------------
	// Frequency input decoder
	// ----------------------------------------
	logic [1:0]         ph_q, ph_d;
	logic signed [15:0] acc_q, acc_d;
	logic signed [15:0] fref_q, fref_d;
	logic signed [1:0]  step;

	always_comb begin
		ph_d = {freq_a_i, freq_b_i};
		// Quadrature counts every edge; freq/dir counts rising A, B is direction
		if (opt_cfg_q[DSF_B_FREQ_FORMAT]) begin
			step = quad_step(ph_q, ph_d);
		end else if (freq_a_i && !ph_q[1]) begin
			step = freq_b_i ? -2'sh1 : 2'sh1;
		end else begin
			step = 2'sh0;
		end
		acc_d  = acc_q + 16'(step);
		fref_d = fref_q;
		// Counts per tick become the frequency reference
		if (tick_i) begin
			fref_d = acc_d;
			acc_d  = 16'sh0;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			// Track the pins through reset so a parked phase does not count on release
			ph_q   <= ph_d;
			acc_q  <= 16'sh0;
			fref_q <= 16'sh0;
		end else begin
			ph_q   <= ph_d;
			acc_q  <= acc_d;
			fref_q <= fref_d;
		end
	end

	// ----------------------------------------
	// Reference select and status word
	// ----------------------------------------
	logic [15:0]        stat_q, stat_d;
	logic signed [15:0] sref_q, sref_d;
	logic signed [15:0] tcmd_q, tcmd_d;
	logic [15:0]        rd_q, rd_d;
	logic signed [16:0] err, spd_abs;
	logic               in_win_rel, in_win_abs;

	always_comb begin
		// Analogue unless digital; then internal or frequency
		if (!spd_cfg_q[DSF_B_DIGITAL_REF]) begin
			sref_d = analog_ref_i;
		end else if (spd_cfg_q[DSF_B_FREQ_REF_SEL]) begin
			sref_d = fref_q;
		end else begin
			sref_d = internal_reference_i;
		end
		// Analogue reference becomes a torque command in torque mode
		tcmd_d = opt_cfg_q[DSF_B_TORQUE_MODE] ? analog_ref_i : 16'sh0;

		err        = 17'(measured_speed_i) - 17'(sref_q);
		spd_abs    = measured_speed_i[15] ? -17'(measured_speed_i) : 17'(measured_speed_i);
		in_win_rel = err < 17'(limits_i.upper) && err > 17'(limits_i.lower);
		in_win_abs = measured_speed_i < limits_i.upper && measured_speed_i > limits_i.lower;

		stat_d = stat_q;
		// Speed comparisons refresh on the loop tick only
		if (tick_i) begin
			stat_d[DSF_B_OVERSPEED]  = spd_abs > 17'(limits_i.overspeed);
			stat_d[DSF_B_IN_SPEED]   = spd_cfg_q[DSF_B_WINDOW_ABS] ? in_win_abs : in_win_rel;
			stat_d[DSF_B_ZERO_SPEED] = measured_speed_i != 16'sh0;
			stat_d[DSF_B_FORWARD]    = !(measured_speed_i > 16'sh0);
		end
		// User alarms written by software
		if (wr_i.en && wr_i.sel == DSF_SEL_STATUS) begin
			stat_d[DSF_B_EXT_ALARM]  = wr_i.data[DSF_B_EXT_ALARM];
			stat_d[DSF_B_AUX_ALARM]  = wr_i.data[DSF_B_AUX_ALARM];
			stat_d[DSF_B_SYNC_WDG_A] = stat_q[DSF_B_SYNC_WDG_A] & wr_i.data[DSF_B_SYNC_WDG_A];
			stat_d[DSF_B_SYNC_WDG_B] = stat_q[DSF_B_SYNC_WDG_B] & wr_i.data[DSF_B_SYNC_WDG_B];
		end
		// Sync wins over a clear in the same cycle
		if (stat_i.sync_msg) begin
			stat_d[DSF_B_SYNC_WDG_A] = 1'b1;
			stat_d[DSF_B_SYNC_WDG_B] = 1'b1;
		end
		stat_d[DSF_B_DRIVE_OK] = !(stat_i.alarm_any || stat_d[DSF_B_EXT_ALARM] || stat_d[DSF_B_AUX_ALARM]);
		stat_d[DSF_B_HW_ENABLE]   = stat_i.hw_enable;
		stat_d[DSF_B_PHASING_OK]  = stat_i.phasing_done;
		stat_d[DSF_B_REG_SAT]     = stat_i.reg_sat;
		stat_d[DSF_B_THERMAL]     = thermal_load_level_i >= DSF_THERMAL_FULL;
		stat_d[DSF_B_CONV_EN]     = stat_i.conv_enabled;
		stat_d[DSF_B_BUS_WARNING] = stat_i.bus_warning;
		stat_d[DSF_B_BUS_OFF]     = stat_i.bus_off;

		// Read data sees the words as they stand this cycle
		unique case (rd_sel_i)
			DSF_SEL_SPEED_CFG:  rd_d = spd_cfg_q;
			DSF_SEL_STATUS:     rd_d = stat_q;
			DSF_SEL_OPTION_CFG: rd_d = opt_cfg_q;
			default:            rd_d = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			stat_q <= 16'h0000;
			sref_q <= 16'sh0;
			tcmd_q <= 16'sh0;
			rd_q   <= 16'h0000;
		end else begin
			stat_q <= stat_d;
			sref_q <= sref_d;
			tcmd_q <= tcmd_d;
			rd_q   <= rd_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rd_data_o               = rd_q;
	assign speed_ref_o             = sref_q;
	assign torque_cmd_o            = tcmd_q;
	assign frequency_reference_o   = fref_q;
	assign torque_mode_o           = opt_cfg_q[DSF_B_TORQUE_MODE];
	assign current_limit_nominal_o = stat_q[DSF_B_THERMAL];
	assign virtual_encoder_en_o    = opt_cfg_q[DSF_B_VIRT_ENC];
	assign supply_low_o            = supply_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	sequence s_sync;
		stat_i.sync_msg;
	endsequence
	sequence s_wdg_set;
		stat_q[DSF_B_SYNC_WDG_A] && stat_q[DSF_B_SYNC_WDG_B];
	endsequence

	property p_ref_sel;
		spd_cfg_q[DSF_B_DIGITAL_REF] && !spd_cfg_q[DSF_B_FREQ_REF_SEL] |=> sref_q == $past(internal_reference_i);
	endproperty
	a_ref_sel: assert property (p_ref_sel) else $error("internal reference not selected");

	property p_analog_ref;
		!spd_cfg_q[DSF_B_DIGITAL_REF] |=> sref_q == $past(analog_ref_i);
	endproperty
	a_analog_ref: assert property (p_analog_ref) else $error("analogue reference not selected");

	property p_overspeed;
		tick_i && measured_speed_i == 16'sh0 |=> !stat_q[DSF_B_OVERSPEED] && !stat_q[DSF_B_ZERO_SPEED];
	endproperty
	a_overspeed: assert property (p_overspeed) else $error("flags wrong at zero speed");

	property p_forward;
		tick_i && measured_speed_i > 16'sh0 |=> !stat_q[DSF_B_FORWARD] && stat_q[DSF_B_ZERO_SPEED];
	endproperty
	a_forward: assert property (p_forward) else $error("forward flag wrong");

	property p_abs_window;
		tick_i && spd_cfg_q[DSF_B_WINDOW_ABS] && measured_speed_i >= limits_i.upper |=> !stat_q[DSF_B_IN_SPEED];
	endproperty
	a_abs_window: assert property (p_abs_window) else $error("in-speed set above window");

	property p_hold;
		!tick_i |=> $stable(stat_q[DSF_B_FORWARD:DSF_B_OVERSPEED]);
	endproperty
	a_hold: assert property (p_hold) else $error("speed flags moved between ticks");

	property p_wdg;
		s_sync |=> s_wdg_set;
	endproperty
	a_wdg: assert property (p_wdg) else $error("watchdog bits not set by sync");

	property p_drive_ok;
		stat_i.alarm_any |=> !stat_q[DSF_B_DRIVE_OK];
	endproperty
	a_drive_ok: assert property (p_drive_ok) else $error("drive ok with alarm");

	property p_thermal;
		thermal_load_level_i >= DSF_THERMAL_FULL |=> current_limit_nominal_o;
	endproperty
	a_thermal: assert property (p_thermal) else $error("current not limited at full load");

	property p_supply;
		started_q |=> $stable(supply_low_o);
	endproperty
	a_supply: assert property (p_supply) else $error("supply selection changed after start");

	property p_bus;
		stat_i.bus_off && stat_i.bus_warning |=> stat_q[DSF_B_BUS_OFF] && stat_q[DSF_B_BUS_WARNING];
	endproperty
	a_bus: assert property (p_bus) else $error("bus error flags not set");

endmodule

`default_nettype wire

// ### logic/dsf_pkg.sv
// Purpose: Shared constants and carriers for the drive status-flag logic
// Assumes: 16-bit signed speed values, thermal load in 0.1 % units
// Notes:   Bit-word selects stand in for the three parameter word numbers
package dsf_pkg;

	// ----------------------------------------
	// Bit-word selects
	// ----------------------------------------
	localparam logic [1:0] DSF_SEL_SPEED_CFG  = 2'h0;
	localparam logic [1:0] DSF_SEL_STATUS     = 2'h1;
	localparam logic [1:0] DSF_SEL_OPTION_CFG = 2'h2;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [15:0] DSF_SPEED_CFG_RST  = 16'h0200;
	localparam logic [15:0] DSF_OPTION_CFG_RST = 16'h0020;

	// ----------------------------------------
	// Speed configuration word fields
	// ----------------------------------------
	localparam int DSF_B_WINDOW_ABS   = 7;
	localparam int DSF_B_DIGITAL_REF  = 12;
	localparam int DSF_B_FREQ_REF_SEL = 13;
	localparam int DSF_B_RESERVED_CFG = 15;

	// ----------------------------------------
	// Status word fields
	// ----------------------------------------
	localparam int DSF_B_OVERSPEED   = 0;
	localparam int DSF_B_IN_SPEED    = 1;
	localparam int DSF_B_ZERO_SPEED  = 2;
	localparam int DSF_B_FORWARD     = 3;
	localparam int DSF_B_DRIVE_OK    = 4;
	localparam int DSF_B_HW_ENABLE   = 5;
	localparam int DSF_B_PHASING_OK  = 6;
	localparam int DSF_B_EXT_ALARM   = 7;
	localparam int DSF_B_AUX_ALARM   = 8;
	localparam int DSF_B_SYNC_WDG_A  = 9;
	localparam int DSF_B_REG_SAT     = 10;
	localparam int DSF_B_THERMAL     = 11;
	localparam int DSF_B_CONV_EN     = 12;
	localparam int DSF_B_BUS_WARNING = 13;
	localparam int DSF_B_BUS_OFF     = 14;
	localparam int DSF_B_SYNC_WDG_B  = 15;

	// ----------------------------------------
	// Option configuration word fields
	// ----------------------------------------
	localparam int DSF_B_VIRT_ENC    = 0;
	localparam int DSF_B_SUPPLY_SEL  = 1;
	localparam int DSF_B_TORQUE_MODE = 2;
	localparam int DSF_B_FREQ_FORMAT = 5;

	// Thermal load full scale: 100.0 % in 0.1 % steps
	localparam logic [15:0] DSF_THERMAL_FULL = 16'h03E8;

	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic        en;
		logic [1:0]  sel;
		logic [15:0] data;
	} dsf_wr_t;

	typedef struct packed {
		logic alarm_any;
		logic hw_enable;
		logic phasing_done;
		logic sync_msg;
		logic reg_sat;
		logic bus_warning;
		logic bus_off;
		logic conv_enabled;
	} dsf_stat_in_t;

	typedef struct packed {
		logic signed [15:0] upper;
		logic signed [15:0] lower;
		logic        [15:0] overspeed;
	} dsf_limits_t;

endpackage

// ### tb/dsf_motor_model.sv
// Purpose: Motor, encoder and field-bus controller seen from the status-flag block
// Assumes: Everything changes on the falling clock edge
// Notes:   Encoder pins keep their phase between moves, as a real encoder does
`timescale 1ns/1ns
`default_nettype none

module dsf_motor_model (
	// Clock
	input  wire logic             clk_sys_i,
	// Far side signals
	output logic signed [15:0]    measured_speed_o,
	output logic                  freq_a_o,
	output logic                  freq_b_o,
	output dsf_pkg::dsf_stat_in_t stat_o
);
	import dsf_pkg::*;

	initial begin
		measured_speed_o = 16'sh0000;
		freq_a_o = 1'b0;
		freq_b_o = 1'b0;
		stat_o = '0;
	end

	task automatic set_speed(input logic signed [15:0] s);
		@(negedge clk_sys_i);
		measured_speed_o = s;
	endtask

	// Forward quadrature: 00, 01, 11, 10, one phase moves per step
	task automatic quad(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys_i);
			if (freq_a_o == freq_b_o) begin
				freq_b_o = !freq_b_o;
			end else begin
				freq_a_o = !freq_a_o;
			end
		end
	endtask

	// Direction settles a cycle ahead of the first edge
	task automatic pulses(input int n, input logic down);
		@(negedge clk_sys_i);
		freq_b_o = down;
		repeat (n) begin
			@(negedge clk_sys_i);
			freq_a_o = 1'b1;
			@(negedge clk_sys_i);
			freq_a_o = 1'b0;
		end
	endtask

	// Bus error levels and drive state; sync is pulsed separately
	task automatic set_levels(input dsf_stat_in_t v);
		@(negedge clk_sys_i);
		stat_o = v;
		stat_o.sync_msg = 1'b0;
	endtask

	task automatic sync_pulse();
		@(negedge clk_sys_i);
		stat_o.sync_msg = 1'b1;
		@(negedge clk_sys_i);
		stat_o.sync_msg = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Purpose: Self-checking bench for the drive status-flag block
// Assumes: Inputs change on the falling edge, results read one edge late
// Notes:   Window limits 50/-50, overspeed 100, reference 200 in the flag sweep
`timescale 1ns/1ns
`default_nettype none

module testbench;
	import dsf_pkg::*;

	logic clk = 1'b0, rstn = 1'b0, tick = 1'b0, supply_saved = 1'b1;
	dsf_wr_t wr = '0;
	dsf_limits_t limits = {16'h0032, 16'hFFCE, 16'h0064};
	logic [1:0] rd_sel = 2'h0;
	logic signed [15:0] analog_ref = 16'sh00C8, internal_ref = 16'sh0016, speed, sref, tcmd, fref;
	logic [15:0] thermal = 16'h0000, rd_data, r;
	logic a, b, tmode, ilim, venc, slow;
	dsf_stat_in_t stat;
	int err_count = 0, checks_done = 0, cycles = 0;

	dsf_status_flags uut (.clk_sys_i(clk), .rstn_i(rstn), .tick_i(tick), .wr_i(wr), .rd_sel_i(rd_sel),
		.rd_data_o(rd_data), .measured_speed_i(speed), .limits_i(limits), .analog_ref_i(analog_ref),
		.internal_reference_i(internal_ref), .thermal_load_level_i(thermal), .supply_saved_i(supply_saved),
		.freq_a_i(a), .freq_b_i(b), .stat_i(stat), .speed_ref_o(sref), .torque_cmd_o(tcmd),
		.frequency_reference_o(fref), .torque_mode_o(tmode), .current_limit_nominal_o(ilim),
		.virtual_encoder_en_o(venc), .supply_low_o(slow));
	dsf_motor_model motor (.clk_sys_i(clk), .measured_speed_o(speed), .freq_a_o(a), .freq_b_o(b),
		.stat_o(stat));

	always #5 clk = !clk;

	// Generous ceiling: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks_done=%0d err_count=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr_word(input logic [1:0] s, input logic [15:0] d);
		@(negedge clk);
		wr = {1'b1, s, d};
		@(negedge clk);
		wr.en = 1'b0;
	endtask

	task automatic rd_word(input logic [1:0] s, output logic [15:0] d);
		@(negedge clk);
		rd_sel = s;
		@(negedge clk);
		d = rd_data;
	endtask

	task automatic do_tick();
		@(negedge clk);
		tick = 1'b1;
		@(negedge clk);
		tick = 1'b0;
	endtask

	function automatic logic [15:0] flags(input int s, input logic absm);
		int e;
		e = absm ? s : s - 200;
		return {12'h000, !(s > 0), s != 0, e < 50 && e > -50, (s < 0 ? -s : s) > 100};
	endfunction

	task automatic t_reset();
		rd_word(DSF_SEL_SPEED_CFG, r);
		chk("speed cfg reset", r, 16'h0200);
		rd_word(DSF_SEL_OPTION_CFG, r);
		chk("option cfg reset", r, 16'h0020);
		rd_word(2'h3, r);
		chk("unused word", r, 16'h0000);
		chk("torque cmd idle", tcmd, 16'h0000);
	endtask

	task automatic t_flags();
		int sp[11] = '{0, 49, 50, -50, -49, 100, 101, -101, 200, 249, 151};
		for (int m = 0; m < 2; m++) begin
			wr_word(DSF_SEL_SPEED_CFG, m ? 16'h0280 : 16'h0200);
			foreach (sp[i]) begin
				motor.set_speed(16'(sp[i]));
				do_tick();
				rd_word(DSF_SEL_STATUS, r);
				chk("speed flags", r & 16'h000F, flags(sp[i], m[0]));
			end
		end
		motor.set_speed(16'sh0000);
		rd_word(DSF_SEL_STATUS, r);
		chk("flags without tick", r & 16'h000F, flags(151, 1'b1));
	endtask

	task automatic t_freq();
		do_tick();
		motor.quad(4);
		do_tick();
		chk("quadrature count", fref, 16'h0004);
		wr_word(DSF_SEL_OPTION_CFG, 16'h0000);
		do_tick();
		motor.pulses(3, 1'b1);
		do_tick();
		chk("freq dir count", fref, 16'hFFFD);
	endtask

	task automatic t_ref();
		logic [15:0] cfg[3] = '{16'h0200, 16'h1200, 16'h3200};
		logic [15:0] exp[3] = '{16'h00C8, 16'h0016, 16'hFFFD};
		foreach (cfg[i]) begin
			wr_word(DSF_SEL_SPEED_CFG, cfg[i]);
			@(negedge clk);
			chk("speed reference", sref, exp[i]);
		end
	endtask

	task automatic t_status();
		thermal = 16'h03E8;
		motor.set_levels(8'b0110_1111);
		rd_word(DSF_SEL_STATUS, r);
		chk("level bits set", r & 16'h7C70, 16'h7C70);
		chk("current limit", ilim, 16'h0001);
		thermal = 16'h03E7;
		motor.set_levels(8'b1000_0000);
		rd_word(DSF_SEL_STATUS, r);
		chk("level bits clear", r & 16'h7C70, 16'h0000);
		motor.set_levels(8'b0000_0000);
		motor.sync_pulse();
		rd_word(DSF_SEL_STATUS, r);
		chk("sync watchdog", r & 16'h8210, 16'h8210);
		wr_word(DSF_SEL_STATUS, 16'h0180);
		rd_word(DSF_SEL_STATUS, r);
		chk("user alarms", r & 16'h8390, 16'h0180);
		wr_word(DSF_SEL_STATUS, 16'h0000);
		rd_word(DSF_SEL_STATUS, r);
		chk("alarms cleared", r & 16'h0190, 16'h0010);
	endtask

	task automatic t_opts();
		analog_ref = 16'sh004D;
		supply_saved = 1'b0;
		wr_word(DSF_SEL_OPTION_CFG, 16'h0025);
		@(negedge clk);
		chk("torque and encoder", {tmode, venc}, 16'h0003);
		chk("torque command", tcmd, 16'h004D);
		wr_word(DSF_SEL_OPTION_CFG, 16'h0026);
		rd_word(DSF_SEL_OPTION_CFG, r);
		chk("option word", r, 16'h0026);
		chk("encoder off", {tmode, venc}, 16'h0002);
		chk("supply kept", slow, 16'h0001);
	endtask

	// Restart: supply selection picks up the saved value, options return to defaults
	task automatic t_restart();
		@(negedge clk);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		chk("supply after restart", slow, 16'h0000);
		rd_word(DSF_SEL_OPTION_CFG, r);
		chk("option cfg restart", r, 16'h0020);
		chk("modes after restart", {tmode, venc}, 16'h0000);
		do_tick();
		chk("no count after restart", fref, 16'h0000);
	endtask

	initial begin
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		chk("supply at start", slow, 16'h0001);
		t_flags();
		t_freq();
		t_ref();
		t_status();
		t_opts();
		t_restart();
		stop_test();
	end
endmodule
`default_nettype wire
